// ---- logic/acs_sequencer.sv ----
// Functional notes
// - Effective result is 11-bit signed two's complement
// - Thirteen result bits, two lowest for correction
// - 160 idle cycles enter automatic powerdown
// - Conversion request wakes converter in 40 cycles
// - Repeat select 0: one conversion, then stop
// - Go reads 1 during 5129-cycle conversion
// - From powerdown, 40 cycles before conversion
// - Result fills high byte and low [7:3]
// - Single conversion done clears go bit
// - Complete interrupt only with both alarms off
// - Enabled upper alarm above threshold interrupts
// - Enabled lower alarm below threshold interrupts
// - Repeat mode: go drops after first, stays 0
// - First repeat conversion sends interrupt request
// - Repeat mode writes result every 256 cycles
// - Clearing repeat select stops further conversions
// - Thresholds compare result bits 11 to 4
// - Negative result: never upper, always lower alarm
// - Threshold crossings set alarm status bits
// - Status updates always; enables gate interrupt
// - One control write configures and starts
// - Disabled converter raises no interrupt
// - Alarm status set by hardware, write-1 clears
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
module acs_sequencer #(
  parameter int CONV_LEN = acs_pkg::CONV_CYCLES
) (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [7:0]                       paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [acs_pkg::RES_WIDTH-1:0]    sampleData,
  output logic      [acs_pkg::SRC_WIDTH-1:0]    inputSourceSelect,
  output logic      [acs_pkg::STAGE_WIDTH-1:0]  inputStageSelect,
  output logic      [1:0]                       referenceLevel,
  output logic                                  referencePinOutput,
  output logic                                  powerDown,
  output logic                                  convBusy,
  output logic                                  resultStrobe,
  output logic                                  irqReq
);
  import acs_pkg::*;

  localparam logic [CNT_WIDTH-1:0] CONV_LAST   = CNT_WIDTH'(CONV_LEN - 1);
  localparam logic [CNT_WIDTH-1:0] WAKE_LAST   = CNT_WIDTH'(WAKE_CYCLES - 1);
  localparam logic [CNT_WIDTH-1:0] IDLE_LAST   = CNT_WIDTH'(IDLE_CYCLES - 1);
  localparam logic [CNT_WIDTH-1:0] REPEAT_LAST =
    CNT_WIDTH'(REPEAT_CYCLES - 1);

  acs_state_t                state_q;
  acs_state_t                state_d;
  logic [CNT_WIDTH-1:0]      cnt_q;
  logic [CNT_WIDTH-1:0]      cnt_d;
  logic [7:0]                ctrl0_q;
  logic [7:0]                ctrl1_q;
  logic [7:0]                upperThr_q;
  logic [7:0]                lowerThr_q;
  logic                      enable_q;
  logic [RES_WIDTH-1:0]      result_q;
  logic [31:0]               rdata_q;
  logic                      irq_q;
  logic                      strobe_q;
  logic                      upperStat_q;
  logic                      lowerStat_q;
  logic                      upperStat_d;
  logic                      lowerStat_d;
  logic                      go_d;

  // Bus decode
  wire        setupPhase = psel & ~penable;
  wire        accessWr   = psel & penable & pwrite;
  wire        selCtrl0   = paddr == ADDR_CTRL0;
  wire        selCtrl1   = paddr == ADDR_CTRL1;
  wire        selResHi   = paddr == ADDR_RES_HIGH;
  wire        selResLo   = paddr == ADDR_RES_LOW;
  wire        selUpper   = paddr == ADDR_UPPER_THR;
  wire        selLower   = paddr == ADDR_LOWER_THR;
  wire        selEnable  = paddr == ADDR_ENABLE;
  wire        selState   = paddr == ADDR_STATE;
  wire        mapped     = selCtrl0 | selCtrl1 | selResHi | selResLo |
                           selUpper | selLower | selEnable | selState;
  wire        wrCtrl0    = accessWr & selCtrl0;
  wire        wrCtrl1    = accessWr & selCtrl1;
  wire        wrEnable   = accessWr & selEnable;
  wire        wrUpper    = accessWr & selUpper;
  wire        wrLower    = accessWr & selLower;
  // Writable fields; go and the status bits are handled apart
  wire [6:0]  ctrl0Wr    = pwdata[CTRL0_REFPIN_BIT:0];
  wire [5:0]  ctrl1Wr    = pwdata[CTRL1_REFHI_BIT:CTRL1_LAEN_BIT];

  // Control fields
  wire        goBit      = ctrl0_q[CTRL0_GO_BIT];
  wire        repeatSel  = ctrl0_q[CTRL0_REPEAT_BIT];
  wire        upperEn    = ctrl1_q[CTRL1_UAEN_BIT];
  wire        lowerEn    = ctrl1_q[CTRL1_LAEN_BIT];

  wire        startReq   = wrCtrl0 & pwdata[CTRL0_GO_BIT] & enable_q;
  wire        isOff      = state_q == ST_OFF;
  wire        isIdle     = state_q == ST_IDLE;
  wire        isConv     = state_q == ST_CONV;
  wire        isRepeat   = state_q == ST_REPEAT;
  wire        canStart   = startReq & (isOff | isIdle);

  // Completion points
  wire        firstDone  = isConv & (cnt_q == CONV_LAST);
  wire        nextDone   = isRepeat & (cnt_q == REPEAT_LAST) & repeatSel;
  wire        convDone   = firstDone | nextDone;

  wire        sampleSign = sampleData[RES_WIDTH-1];
  wire [7:0]  cmpBits    = sampleData[RES_WIDTH-2:RES_WIDTH-9];
  wire        upperHit   = ~sampleSign & (cmpBits > upperThr_q);
  wire        lowerHit   = sampleSign | (cmpBits < lowerThr_q);

  wire        completeIrq = ~upperEn & ~lowerEn;
  wire        alarmIrq    = (upperEn & upperHit) | (lowerEn & lowerHit);
  wire        firstRepIrq = firstDone & repeatSel;
  wire        irqEvent    = convDone & enable_q &
                            (completeIrq | alarmIrq | firstRepIrq);

  wire        clrUpper    = wrCtrl1 & pwdata[CTRL1_UAST_BIT];
  wire        clrLower    = wrCtrl1 & pwdata[CTRL1_LAST_BIT];
  wire        setUpper    = convDone & upperHit;
  wire        setLower    = convDone & lowerHit;

  always_comb begin
    upperStat_d = upperStat_q;
    lowerStat_d = lowerStat_q;
    if (clrUpper) begin
      upperStat_d = 1'b0;
    end
    if (clrLower) begin
      lowerStat_d = 1'b0;
    end
    if (setUpper) begin
      upperStat_d = 1'b1;
    end
    if (setLower) begin
      lowerStat_d = 1'b1;
    end
  end

  // Go bit: software may only set it while the converter is free
  always_comb begin
    go_d = goBit;
    if (canStart) begin
      go_d = 1'b1;
    end
    if (firstDone) begin
      go_d = 1'b0;
    end
  end

  // Sequencer
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + CNT_WIDTH'(1);
    unique case (state_q)
      ST_OFF: begin
        cnt_d = '0;
        if (canStart) begin
          state_d = ST_WAKE;
        end
      end
      ST_IDLE: begin
        if (canStart) begin
          state_d = ST_CONV;
          cnt_d   = '0;
        end else if (cnt_q == IDLE_LAST) begin
          state_d = ST_OFF;
          cnt_d   = '0;
        end
      end
      ST_WAKE: begin
        if (cnt_q == WAKE_LAST) begin
          state_d = ST_CONV;
          cnt_d   = '0;
        end
      end
      ST_CONV: begin
        if (cnt_q == CONV_LAST) begin
          cnt_d   = '0;
          state_d = repeatSel ? ST_REPEAT : ST_IDLE;
        end
      end
      ST_REPEAT: begin
        if (!repeatSel || !enable_q) begin
          state_d = ST_IDLE;
          cnt_d   = '0;
        end else if (cnt_q == REPEAT_LAST) begin
          cnt_d = '0;
        end
      end
    endcase
  end

  // Read mux; captured in setup so data comes from a flip-flop
  logic [31:0] rdMux;
  always_comb begin
    rdMux = '0;
    if (selCtrl0) begin
      rdMux[7:0] = ctrl0_q;
    end
    if (selCtrl1) begin
      rdMux[7:0] = {ctrl1_q[7:2], upperStat_q, lowerStat_q};
    end
    if (selResHi) begin
      rdMux[7:0] = result_q[RES_WIDTH-1:RES_WIDTH-8];
    end
    if (selResLo) begin
      rdMux[7:RES_LOW_LSB] = result_q[RES_WIDTH-9:0];
    end
    if (selUpper) begin
      rdMux[7:0] = upperThr_q;
    end
    if (selLower) begin
      rdMux[7:0] = lowerThr_q;
    end
    if (selEnable) begin
      rdMux[0] = enable_q;
    end
    if (selState) begin
      rdMux[1:0] = {convBusy, powerDown};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_OFF;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl0_q <= CTRL0_RESET;
    end else if (wrCtrl0) begin
      ctrl0_q <= {go_d, ctrl0Wr};
    end else begin
      ctrl0_q[CTRL0_GO_BIT] <= go_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl1_q <= CTRL1_RESET;
    end else if (wrCtrl1) begin
      ctrl1_q <= {ctrl1Wr, 2'b00};
    end
  end

  // Status flops; a same-cycle set beats the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      upperStat_q <= 1'b0;
      lowerStat_q <= 1'b0;
    end else begin
      upperStat_q <= upperStat_d;
      lowerStat_q <= lowerStat_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      upperThr_q <= THR_RESET;
      lowerThr_q <= THR_RESET;
      enable_q   <= ENABLE_RESET;
    end else begin
      if (wrUpper) begin
        upperThr_q <= pwdata[7:0];
      end
      if (wrLower) begin
        lowerThr_q <= pwdata[7:0];
      end
      if (wrEnable) begin
        enable_q <= pwdata[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result_q <= '0;
      irq_q    <= 1'b0;
      strobe_q <= 1'b0;
      rdata_q  <= '0;
    end else begin
      if (convDone) begin
        result_q <= sampleData;
      end
      irq_q    <= irqEvent;
      strobe_q <= convDone;
      if (setupPhase) begin
        rdata_q <= rdMux;
      end
    end
  end

  // Zero-wait slave keeps the CPU path short
  assign pready             = 1'b1;
  assign pslverr            = psel & penable & ~mapped;
  assign prdata             = rdata_q;
  assign inputSourceSelect  = ctrl0_q[CTRL0_SRC_LSB +: SRC_WIDTH];
  assign inputStageSelect   = ctrl1_q[CTRL1_STAGE_LSB +: STAGE_WIDTH];
  assign referenceLevel     = {ctrl1_q[CTRL1_REFHI_BIT],
                               ctrl0_q[CTRL0_REFLO_BIT]};
  assign referencePinOutput = ctrl0_q[CTRL0_REFPIN_BIT];
  assign powerDown          = isOff;
  assign convBusy           = ~(isOff | isIdle);
  assign resultStrobe       = strobe_q;
  assign irqReq             = irq_q;
endmodule : acs_sequencer

// ---- logic/acs_pkg.sv ----
package acs_pkg;
  // APB byte addresses
  localparam logic [7:0] ADDR_CTRL0     = 8'h00;
  localparam logic [7:0] ADDR_CTRL1     = 8'h04;
  localparam logic [7:0] ADDR_RES_HIGH  = 8'h08;
  localparam logic [7:0] ADDR_RES_LOW   = 8'h0c;
  localparam logic [7:0] ADDR_UPPER_THR = 8'h10;
  localparam logic [7:0] ADDR_LOWER_THR = 8'h14;
  localparam logic [7:0] ADDR_ENABLE    = 8'h18;
  localparam logic [7:0] ADDR_STATE     = 8'h1c;

  // Control register 0 fields
  localparam int CTRL0_GO_BIT     = 7;
  localparam int CTRL0_REFPIN_BIT = 6;
  localparam int CTRL0_REPEAT_BIT = 5;
  localparam int CTRL0_REFLO_BIT  = 4;
  localparam int CTRL0_SRC_LSB    = 0;
  localparam int SRC_WIDTH        = 4;

  // Control/status register 1 fields
  localparam int CTRL1_REFHI_BIT  = 7;
  localparam int CTRL1_STAGE_LSB  = 4;
  localparam int STAGE_WIDTH      = 3;
  localparam int CTRL1_UAEN_BIT   = 3;
  localparam int CTRL1_LAEN_BIT   = 2;
  localparam int CTRL1_UAST_BIT   = 1;
  localparam int CTRL1_LAST_BIT   = 0;

  // Result layout
  localparam int RES_WIDTH        = 13;
  localparam int RES_LOW_LSB      = 3;

  // Reset values
  localparam logic [7:0] CTRL0_RESET  = 8'h00;
  localparam logic [7:0] CTRL1_RESET  = 8'h00;
  localparam logic [7:0] THR_RESET    = 8'h00;
  localparam logic       ENABLE_RESET = 1'b1;

  // Timing in system clock cycles
  localparam int CONV_CYCLES    = 5129;
  localparam int WAKE_CYCLES    = 40;
  localparam int IDLE_CYCLES    = 160;
  localparam int REPEAT_CYCLES  = 256;
  localparam int CNT_WIDTH      = 16;

  typedef enum logic [4:0] {
    ST_OFF    = 5'b00001,
    ST_IDLE   = 5'b00010,
    ST_WAKE   = 5'b00100,
    ST_CONV   = 5'b01000,
    ST_REPEAT = 5'b10000
  } acs_state_t;
endpackage : acs_pkg

// ---- bench/acs_analog_src.sv ----
`timescale 1ns/1ps
// Front end stand-in; its word only moves at clock edges
module acs_analog_src (
  input  wire logic        clk,
  input  wire logic [12:0] level,
  output logic      [12:0] sampleData
);
  always_ff @(posedge clk) sampleData <= level;
endmodule : acs_analog_src

// ---- bench/acs_sequencer_assertions.sv ----
`timescale 1ns/1ps
module acs_sequencer_assertions
  import acs_pkg::*;
#(parameter int CONV_LEN = CONV_CYCLES) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [12:0] sampleData,
  input wire logic [3:0]  inputSourceSelect,
  input wire logic [2:0]  inputStageSelect,
  input wire logic [1:0]  referenceLevel,
  input wire logic        referencePinOutput,
  input wire logic        powerDown,
  input wire logic        convBusy,
  input wire logic        resultStrobe,
  input wire logic        irqReq
);
  localparam int LoS = CONV_LEN;
  localparam int HiS = CONV_LEN + 1;
  localparam int LoP = CONV_LEN + 40;
  localparam int HiP = CONV_LEN + 41;
  logic       ctrlWr;
  logic       enWr;
  logic       enQ;
  logic [8:0] idleQ;
  logic [8:0] idleD;
  assign ctrlWr = psel && penable && pwrite && paddr == ADDR_CTRL0;
  // Saturates so a long idle stretch cannot wrap
  assign idleD = (convBusy || powerDown) ? 9'h000 :
                 idleQ + {8'h00, idleQ != 9'h1ff};
  always_ff @(posedge clk) idleQ <= rst ? 9'h000 : idleD;
  // Mirror of the enable register as software wrote it
  assign enWr = psel && penable && pwrite && paddr == ADDR_ENABLE;
  always_ff @(posedge clk) enQ <= rst ? ENABLE_RESET : enWr ? pwdata[0] : enQ;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence goIdle(bit rep);
    ctrlWr && pwdata[7] && pwdata[5] == rep && !convBusy && !powerDown &&
    enQ;
  endsequence
  sequence goAsleep;
    ctrlWr && pwdata[7] && powerDown && enQ;
  endsequence
  single_stop_a: assert property (
    goIdle(1'b0) |-> ##[LoS:HiS] (resultStrobe && !convBusy))
    else $error("single conversion timing");
  repeat_first_a: assert property (
    goIdle(1'b1) |-> ##[LoS:HiS] (resultStrobe && irqReq && convBusy))
    else $error("first repeat result");
  wake_exit_a: assert property (
    goAsleep |=> convBusy && !powerDown) else $error("no wake");
  wake_len_a: assert property (
    goAsleep |-> ##[LoP:HiP] resultStrobe) else $error("wake length");
  idle_pd_a: assert property (
    $rose(powerDown) |-> idleQ >= 9'h09f && idleQ <= 9'h0a1)
    else $error("powerdown timing");
  irq_result_a: assert property (
    irqReq |-> resultStrobe) else $error("irq without result");
  irq_off_a: assert property (
    irqReq |-> $past(enQ)) else $error("irq while disabled");
  repeat_gap_a: assert property (
    resultStrobe && convBusy |-> ##256 (resultStrobe || !convBusy))
    else $error("repeat spacing");
  cfg_take_a: assert property (
    ctrlWr && !convBusy |=> inputSourceSelect == $past(pwdata[3:0]))
    else $error("source not taken");
endmodule : acs_sequencer_assertions

bind acs_sequencer acs_sequencer_assertions #(.CONV_LEN(CONV_LEN)) i_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sampleData(sampleData),
  .inputSourceSelect(inputSourceSelect), .inputStageSelect(inputStageSelect),
  .referenceLevel(referenceLevel), .referencePinOutput(referencePinOutput),
  .powerDown(powerDown), .convBusy(convBusy), .resultStrobe(resultStrobe),
  .irqReq(irqReq));

// ---- bench/acs_sequencer_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, x) begin nCompared++; if ((g) !== (x)) begin errTotal++; \
  $display("wrong value at %0t: %h vs %h", $time, g, x); end end
module acs_sequencer_tb;
  import acs_pkg::*;
  localparam int CLEN = 20;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic        powerDown, convBusy, resultStrobe, irqReq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] level, sampleData;
  logic [3:0]  srcSel;
  logic [2:0]  stageSel;
  logic [1:0]  refLvl;
  logic        refPin;
  int          errTotal, nCompared, n;

  acs_analog_src i_src (.clk(clk), .level(level), .sampleData(sampleData));
  acs_sequencer #(.CONV_LEN(CLEN)) i_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampleData(sampleData),
    .inputSourceSelect(srcSel), .inputStageSelect(stageSel),
    .referenceLevel(refLvl), .referencePinOutput(refPin),
    .powerDown(powerDown), .convBusy(convBusy),
    .resultStrobe(resultStrobe), .irqReq(irqReq));

  task automatic completeRun;
    $display("mismatches %0d, compares %0d", errTotal, nCompared);
    if (errTotal == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : completeRun

  task automatic apb(input logic wr, input logic [7:0] a, d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errTotal++;
      completeRun();
    end
  endtask : apb

  // Bounded wait; returns in the strobe cycle, off the clock edge
  task automatic waitStrobe;
    for (n = 1; n < 6000; n++) begin
      @(negedge clk);
      if (resultStrobe === 1'b1) return;
    end
    errTotal++;
    completeRun();
  endtask : waitStrobe

  task automatic tRegs;
    apb(1'b0, ADDR_STATE, 8'h00);
    `CHK(rd[1:0], 2'b01)
    apb(1'b0, ADDR_ENABLE, 8'h00);
    `CHK(rd, 32'h1)
    apb(1'b0, 8'h20, 8'h00);
    `CHK({er, rd}, 33'h100000000)
  endtask : tRegs

  task automatic tSingle;
    level <= 13'h0123;
    apb(1'b1, ADDR_CTRL1, 8'hb0);
    apb(1'b1, ADDR_CTRL0, 8'hd5);
    apb(1'b0, ADDR_CTRL0, 8'h00);
    `CHK(rd[7], 1'b1)
    `CHK(srcSel, 4'h5)
    `CHK({refLvl, refPin, stageSel}, 6'h3b)
    waitStrobe();
    `CHK(irqReq, 1'b1)
    apb(1'b0, ADDR_CTRL0, 8'h00);
    `CHK(rd[7], 1'b0)
    apb(1'b0, ADDR_RES_HIGH, 8'h00);
    `CHK(rd, {24'h0, 8'h09})
    apb(1'b0, ADDR_RES_LOW, 8'h00);
    `CHK(rd, {24'h0, 5'h03, 3'h0})
    repeat (170) @(posedge clk);
    apb(1'b0, ADDR_STATE, 8'h00);
    `CHK(rd[0], 1'b1)
  endtask : tSingle

  task automatic tDisable;
    apb(1'b1, ADDR_CTRL0, 8'h80);
    apb(1'b1, ADDR_ENABLE, 8'h00);
    waitStrobe();
    `CHK(irqReq, 1'b0)
    apb(1'b1, ADDR_CTRL0, 8'h80);
    apb(1'b0, ADDR_CTRL0, 8'h00);
    `CHK(rd[7], 1'b0)
    apb(1'b1, ADDR_ENABLE, 8'h01);
  endtask : tDisable

  task automatic tAlarm;
    logic [12:0] sv [5] = '{13'h0400, 13'h0415, 13'h1f00, 13'h0100,
                            13'h0500};
    logic [1:0]  en [5] = '{2'b10, 2'b10, 2'b01, 2'b00, 2'b01};
    logic        up, lo;
    apb(1'b1, ADDR_UPPER_THR, 8'h40);
    apb(1'b1, ADDR_LOWER_THR, 8'h20);
    for (int i = 0; i < 5; i++) begin
      up = !sv[i][12] && sv[i][11:4] > 8'h40;
      lo = sv[i][12] || sv[i][11:4] < 8'h20;
      level <= sv[i];
      // Writing ones to the status bits clears them first
      apb(1'b1, ADDR_CTRL1, {4'h0, en[i], 2'b11});
      apb(1'b1, ADDR_CTRL0, 8'h80);
      waitStrobe();
      `CHK(irqReq, en[i][1] & up | en[i][0] & lo | en[i] == 2'b00)
      apb(1'b0, ADDR_CTRL1, 8'h00);
      `CHK(rd[1:0], {up, lo})
    end
  endtask : tAlarm

  task automatic tRepeat;
    int k;
    level <= 13'h0200;
    // Upper alarm armed but never hit
    apb(1'b1, ADDR_CTRL1, 8'h08);
    apb(1'b1, ADDR_CTRL0, 8'ha0);
    waitStrobe();
    `CHK(irqReq, 1'b1)
    waitStrobe();
    `CHK(n, 256)
    `CHK(irqReq, 1'b0)
    @(posedge clk);
    level <= 13'h1a08;
    apb(1'b0, ADDR_CTRL0, 8'h00);
    `CHK(rd[7], 1'b0)
    waitStrobe();
    apb(1'b0, ADDR_RES_HIGH, 8'h00);
    `CHK(rd, {24'h0, 8'hd0})
    apb(1'b1, ADDR_CTRL0, 8'h00);
    k = 0;
    repeat (300) begin
      @(negedge clk);
      if (resultStrobe !== 1'b0) k++;
    end
    `CHK({k, convBusy}, {32'h0, 1'b0})
  endtask : tRepeat

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {rst, psel, penable, pwrite} = 4'h8;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = 13'h0000;
    errTotal = 0;
    nCompared = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tRegs();
    tSingle();
    tDisable();
    tAlarm();
    tRepeat();
    completeRun();
  end
endmodule : acs_sequencer_tb
